// ==== ctp_top.v ====
// cascadable timer pair: two timer pairs, AHB-Lite registers, interrupts and DMA request
`timescale 1ns/10ps
`include "ctp_regs.vh"
module ctp_top (
  input wire hclk, // system clock, 100 MHz
  input wire hresetn, // async reset, active low
  input wire hsel, // slave select
  input wire [7:0] haddr, // byte address
  input wire [1:0] htrans, // transfer type
  input wire hwrite, // write when high
  input wire [2:0] hsize, // transfer size
  input wire [31:0] hwdata, // write data
  input wire hready, // bus ready in
  output wire hreadyout, // always ready
  output wire hresp, // always OKAY
  output reg [31:0] hrdata, // read data
  input wire [3:0] external_count_pin, // count pins; bit 0 feeds timers 2 and 3, bit 2 timers 4 and 5, bits 1 and 3 unused
  input wire [3:0] gate_pin, // gate pins; bit 0 feeds timers 2 and 3, bit 2 timers 4 and 5, bits 1 and 3 unused
  input wire cpu_idle, // core idle state
  output wire irq, // level interrupt
  output wire [2:0] irq_priority, // priority of highest pending source
  output wire dma_request // one-cycle DMA trigger
);
  ////////////////////////////////////////////////////////////////////////
  // bus slave
  reg [7:0] addr_ff;
  reg wr_ff;
  reg rd_ff;
  wire take = hsel && hready && htrans[1];
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_ff <= 8'h00;
      wr_ff <= 1'b0;
      rd_ff <= 1'b0;
    end else begin
      addr_ff <= take ? haddr : addr_ff;
      wr_ff <= take && hwrite;
      rd_ff <= take && !hwrite;
    end
  end
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  wire wr_now = wr_ff;
  ////////////////////////////////////////////////////////////////////////
  // registers
  reg [15:0] ctrl_ff [0:3];
  reg [15:0] period_ff [0:3];
  reg [3:0] irq_stat_ff;
  reg [3:0] irq_mask_ff;
  reg [11:0] irq_prio_ff;
  wire [15:0] count [0:3];
  wire [3:0] match;
  wire [3:0] carry;
  wire [3:0] tick;
  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  reg [3:0] ext_s1_ff;
  reg [3:0] ext_s2_ff;
  reg [3:0] ext_s3_ff;
  reg [3:0] gate_s1_ff;
  reg [3:0] gate_s2_ff;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ext_s1_ff <= 4'h0;
      ext_s2_ff <= 4'h0;
      ext_s3_ff <= 4'h0;
      gate_s1_ff <= 4'h0;
      gate_s2_ff <= 4'h0;
    end else begin
      ext_s1_ff <= external_count_pin;
      ext_s2_ff <= ext_s1_ff;
      ext_s3_ff <= ext_s2_ff;
      gate_s1_ff <= gate_pin;
      gate_s2_ff <= gate_s1_ff;
    end
  end
  wire [3:0] ext_rise = ext_s2_ff & ~ext_s3_ff;
  ////////////////////////////////////////////////////////////////////////
  // timers; index 0,1 = pair A low/high, 2,3 = pair B low/high
  wire [1:0] joined;
  assign joined[0] = ctrl_ff[0][`CTP_BIT_CASCADE_ENABLE];
  assign joined[1] = ctrl_ff[2][`CTP_BIT_CASCADE_ENABLE];
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : gen_tmr
      localparam integer LO = (g / 2) * 2;
      wire is_hi = (g % 2) == 1;
      wire j = joined[g / 2];
      // joined halves take setup from the low control, idle stop is per half
      wire [15:0] cfg = j ? ctrl_ff[LO] : ctrl_ff[g];
      wire idle_stop = cpu_idle && ctrl_ff[g][`CTP_BIT_STOP_IN_IDLE];
      wire jm = j && (count[LO + 1] == period_ff[LO + 1]) && (count[LO] == period_ff[LO]) && tick[LO];
      ctp_timer16 u_tmr (
        .hclk(hclk),
        .hresetn(hresetn),
        .timer_on(cfg[`CTP_BIT_TIMER_ON]),
        .idle_stop(idle_stop),
        .clock_source_select(cfg[`CTP_BIT_CLOCK_SOURCE]),
        .gate_enable(cfg[`CTP_BIT_GATE_ENABLE]),
        .prescale_select(cfg[`CTP_BIT_PS_HI:`CTP_BIT_PS_LO]),
        .ext_rise(ext_rise[LO]),
        .gate_level(gate_s2_ff[LO]),
        .slave(j && is_hi),
        .joined_low(j && !is_hi),
        .carry_in(is_hi ? carry[LO] : 1'b0),
        .joined_match(jm),
        .period(period_ff[g]),
        .wr_cnt(wr_now && addr_ff == (`CTP_OFF_CNT_LO_A + g * 4)),
        .wdata(hwdata[15:0]),
        .count_ff(count[g]),
        .carry_out(carry[g]),
        .tick(tick[g]),
        .match_ff(match[g])
      );
    end
  endgenerate
  // joined event goes to the high half's flag only
  wire [3:0] event_in;
  assign event_in[0] = match[0] && !joined[0];
  assign event_in[1] = joined[0] ? match[0] : match[1];
  assign event_in[2] = match[2] && !joined[1];
  assign event_in[3] = joined[1] ? match[2] : match[3];
  assign dma_request = event_in[0] || event_in[1];
  ////////////////////////////////////////////////////////////////////////
  // register writes and interrupt status
  wire rd_stat = rd_ff && (addr_ff == `CTP_OFF_IRQ_STAT);
  integer i;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (i = 0; i < 4; i = i + 1) begin
        ctrl_ff[i] <= `CTP_RST_CTRL;
        period_ff[i] <= `CTP_RST_PERIOD;
      end
      irq_stat_ff <= 4'h0;
      irq_mask_ff <= `CTP_RST_MASK;
      irq_prio_ff <= `CTP_RST_PRIO;
    end else begin
      for (i = 0; i < 4; i = i + 1) begin
        if (wr_now && addr_ff == (`CTP_OFF_CTRL_LO_A + i * 4))
          ctrl_ff[i] <= hwdata[15:0] & `CTP_CTRL_WMASK;
        if (wr_now && addr_ff == (`CTP_OFF_PER_LO_A + i * 4))
          period_ff[i] <= hwdata[15:0];
      end
      if (wr_now && addr_ff == `CTP_OFF_IRQ_MASK)
        irq_mask_ff <= hwdata[3:0];
      if (wr_now && addr_ff == `CTP_OFF_IRQ_PRIO)
        irq_prio_ff <= hwdata[11:0];
      // clear only what the read returned, so an event landing after the capture is kept; set wins
      irq_stat_ff <= (rd_stat ? (irq_stat_ff & ~hrdata[3:0]) : irq_stat_ff) | event_in;
    end
  end
  // masked, low-half enables ignored when joined
  wire [3:0] en_eff = irq_mask_ff & {1'b1, !joined[1], 1'b1, !joined[0]};
  wire [3:0] pend = irq_stat_ff & en_eff;
  assign irq = |pend;
  reg [2:0] best;
  integer k;
  always @* begin
    best = 3'h0;
    for (k = 0; k < 4; k = k + 1)
      if (pend[k] && irq_prio_ff[k * 3 +: 3] > best)
        best = irq_prio_ff[k * 3 +: 3];
  end
  assign irq_priority = best;
  ////////////////////////////////////////////////////////////////////////
  // read mux; counts read live at any time
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      hrdata <= 32'h00000000;
    else if (take && !hwrite) begin
      case (haddr)
        `CTP_OFF_CTRL_LO_A: hrdata <= {16'h0000, ctrl_ff[0]};
        `CTP_OFF_CTRL_HI_A: hrdata <= {16'h0000, ctrl_ff[1]};
        `CTP_OFF_CTRL_LO_B: hrdata <= {16'h0000, ctrl_ff[2]};
        `CTP_OFF_CTRL_HI_B: hrdata <= {16'h0000, ctrl_ff[3]};
        `CTP_OFF_CNT_LO_A: hrdata <= {16'h0000, count[0]};
        `CTP_OFF_CNT_HI_A: hrdata <= {16'h0000, count[1]};
        `CTP_OFF_CNT_LO_B: hrdata <= {16'h0000, count[2]};
        `CTP_OFF_CNT_HI_B: hrdata <= {16'h0000, count[3]};
        `CTP_OFF_PER_LO_A: hrdata <= {16'h0000, period_ff[0]};
        `CTP_OFF_PER_HI_A: hrdata <= {16'h0000, period_ff[1]};
        `CTP_OFF_PER_LO_B: hrdata <= {16'h0000, period_ff[2]};
        `CTP_OFF_PER_HI_B: hrdata <= {16'h0000, period_ff[3]};
        `CTP_OFF_IRQ_STAT: hrdata <= {28'h0000000, irq_stat_ff};
        `CTP_OFF_IRQ_MASK: hrdata <= {28'h0000000, irq_mask_ff};
        `CTP_OFF_IRQ_PRIO: hrdata <= {20'h00000, irq_prio_ff};
        default: hrdata <= 32'h00000000;
      endcase
    end
  end
endmodule

// ==== ctp_regs.vh ====
// register map, field positions, reset values and timing constants of the cascadable timer pair
`ifndef CTP_REGS_VH
`define CTP_REGS_VH
// byte offsets (one 32-bit word each)
`define CTP_OFF_CTRL_LO_A 8'h00
`define CTP_OFF_CTRL_HI_A 8'h04
`define CTP_OFF_CTRL_LO_B 8'h08
`define CTP_OFF_CTRL_HI_B 8'h0C
`define CTP_OFF_CNT_LO_A 8'h10
`define CTP_OFF_CNT_HI_A 8'h14
`define CTP_OFF_CNT_LO_B 8'h18
`define CTP_OFF_CNT_HI_B 8'h1C
`define CTP_OFF_PER_LO_A 8'h20
`define CTP_OFF_PER_HI_A 8'h24
`define CTP_OFF_PER_LO_B 8'h28
`define CTP_OFF_PER_HI_B 8'h2C
`define CTP_OFF_IRQ_STAT 8'h30
`define CTP_OFF_IRQ_MASK 8'h34
`define CTP_OFF_IRQ_PRIO 8'h38
`define CTP_OFF_IDLE 8'h3C
// control register fields
`define CTP_BIT_TIMER_ON 15
`define CTP_BIT_STOP_IN_IDLE 13
`define CTP_BIT_GATE_ENABLE 6
`define CTP_BIT_PS_HI 5
`define CTP_BIT_PS_LO 4
`define CTP_BIT_CASCADE_ENABLE 3
`define CTP_BIT_CLOCK_SOURCE 1
`define CTP_CTRL_WMASK 16'hA07A
// reset values
`define CTP_RST_CTRL 16'h0000
`define CTP_RST_PERIOD 16'hFFFF
`define CTP_RST_MASK 4'h0
`define CTP_RST_PRIO 12'h000
// prescale divide ratios (as log2), select 0..3 = 1:1, 1:8, 1:64, 1:256
`define CTP_PS_SHIFT0 4'h0
`define CTP_PS_SHIFT1 4'h3
`define CTP_PS_SHIFT2 4'h6
`define CTP_PS_SHIFT3 4'h8
// mode codes from {clock source, gate}
`define CTP_MODE_TIMER 2'h0
`define CTP_MODE_GATED 2'h1
`define CTP_MODE_SYNC 2'h2
`endif

// ==== ctp_timer16.v ====
// one 16-bit timer half: mode choice, prescaler, count, period match and carry chaining
`timescale 1ns/10ps
`include "ctp_regs.vh"
module ctp_timer16 (
  input wire hclk, // system clock
  input wire hresetn, // async reset, active low
  input wire timer_on, // counting allowed
  input wire idle_stop, // stop because of idle
  input wire clock_source_select, // 1: external count pin
  input wire gate_enable, // gated timer mode
  input wire [1:0] prescale_select, // prescaler ratio
  input wire ext_rise, // synchronised rising edge of the count pin
  input wire gate_level, // synchronised gate pin level
  input wire slave, // high word of a joined pair: counts on carry
  input wire joined_low, // low word of a joined pair: no match on its own word
  input wire carry_in, // carry from the low word
  input wire joined_match, // full 32-bit match while joined
  input wire [15:0] period, // own period value
  input wire wr_cnt, // software write of the count
  input wire [15:0] wdata, // count write data
  output reg [15:0] count_ff, // running count
  output wire carry_out, // count step that rolls over to the partner
  output wire tick, // count step taken this cycle
  output reg match_ff // one-cycle period match event
);
  reg [7:0] ps_ff;
  reg gate_q_ff;
  reg [1:0] mode;
  reg [3:0] shift;
  reg src;
  wire ps_done;
  wire own_match;
  wire gate_fall;
  always @* begin
    if (clock_source_select)
      mode = `CTP_MODE_SYNC;
    else if (gate_enable)
      mode = `CTP_MODE_GATED;
    else
      mode = `CTP_MODE_TIMER;
  end
  // instruction clock in timer and gated modes, pin in counter mode
  always @* begin
    case (mode)
      `CTP_MODE_SYNC: src = ext_rise;
      `CTP_MODE_GATED: src = gate_level;
      default: src = 1'b1;
    endcase
    case (prescale_select)
      2'h0: shift = `CTP_PS_SHIFT0;
      2'h1: shift = `CTP_PS_SHIFT1;
      2'h2: shift = `CTP_PS_SHIFT2;
      default: shift = `CTP_PS_SHIFT3;
    endcase
  end
  wire run = timer_on && !idle_stop;
  assign ps_done = (shift == 4'h0) || (ps_ff == ((9'h001 << shift) - 9'h001));
  wire step = run && src && ps_done;
  assign tick = slave ? (run && carry_in) : step;
  assign own_match = (count_ff == period);
  assign carry_out = tick && (count_ff == 16'hFFFF) && !joined_match;
  assign gate_fall = gate_q_ff && !gate_level;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ps_ff <= 8'h00;
      count_ff <= 16'h0000;
      match_ff <= 1'b0;
      gate_q_ff <= 1'b0;
    end else begin
      gate_q_ff <= gate_level;
      match_ff <= 1'b0;
      if (!run)
        ps_ff <= 8'h00;
      else if (src && !slave)
        ps_ff <= ps_done ? 8'h00 : ps_ff + 8'h01;
      // both halves of a joined pair clear on the same edge; the carry is held off then
      if (wr_cnt)
        count_ff <= wdata;
      else if (joined_match) begin
        count_ff <= 16'h0000;
        match_ff <= 1'b1;
      end else if (tick) begin
        if (own_match && !slave && !joined_low) begin
          count_ff <= 16'h0000;
          match_ff <= 1'b1;
        end else
          count_ff <= count_ff + 16'h0001;
      end
      // gated mode flags the end of a gate window
      if (mode == `CTP_MODE_GATED && gate_fall && run && !slave)
        match_ff <= 1'b1;
    end
  end
endmodule

// ==== ctp_top_asserts.sv ====
// bus and interrupt checker for the cascadable timer pair top
`timescale 1ns/10ps
module ctp_top_asserts (
  input wire hclk, // clock
  input wire hresetn, // reset, low
  input wire hsel, // select
  input wire [7:0] haddr, // address
  input wire [1:0] htrans, // transfer type
  input wire hwrite, // write
  input wire hready, // bus ready
  input wire hreadyout, // slave ready
  input wire hresp, // response
  input wire [31:0] hrdata, // read data
  input wire irq, // interrupt
  input wire dma_request // dma trigger
);
  wire acc = hsel && hready && htrans[1];
  wire rd_acc = acc && !hwrite;
  reg a_wr_ff;
  reg mask_wr_ff;
  reg [2:0] acc_hist_ff;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      a_wr_ff <= 1'b0;
      mask_wr_ff <= 1'b0;
      acc_hist_ff <= 3'h0;
    end else begin
      a_wr_ff <= a_wr_ff | (acc && hwrite && (haddr == 8'h00 || haddr == 8'h04));
      mask_wr_ff <= mask_wr_ff | (acc && hwrite && haddr == 8'h34);
      acc_hist_ff <= {acc_hist_ff[1:0], acc};
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  AST_HRESP_OKAY: assert property (hresp == 1'b0) else $error("error response seen");
  AST_ZERO_WAIT: assert property (hreadyout == 1'b1) else $error("wait state seen");
  AST_DMA_ONE_CYCLE: assert property (dma_request |=> !dma_request) else $error("dma pulse too long");
  AST_DMA_PAIR_A_ONLY: assert property (!a_wr_ff |-> !dma_request) else $error("dma without pair a");
  AST_IRQ_NEEDS_MASK: assert property (!mask_wr_ff |-> !irq) else $error("irq while masked");
  AST_IRQ_STICKY: assert property ($fell(irq) |-> acc_hist_ff != 3'h0) else $error("irq dropped alone");
  AST_HRDATA_HOLD: assert property (!$stable(hrdata) |-> $past(rd_acc)) else $error("hrdata moved");
  AST_UNMAPPED_ZERO: assert property (rd_acc && haddr >= 8'h40 |=> hrdata == 32'h0) else $error("unmapped");
endmodule
bind ctp_top ctp_top_asserts u_ctp_top_asserts (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready,
  .hreadyout, .hresp, .hrdata, .irq, .dma_request);

// ==== tb.sv ====
// self-checking testbench for the cascadable timer pair
`timescale 1ns/10ps
`include "ctp_regs.vh"
module tb;
  reg hclk, hresetn, hsel, hwrite, cpu_idle;
  reg [7:0] haddr;
  reg [1:0] htrans;
  reg [2:0] hsize;
  reg [31:0] hwdata, rd;
  reg [3:0] external_count_pin, gate_pin;
  wire hready, hreadyout, hresp, irq, dma_request;
  wire [31:0] hrdata;
  wire [2:0] irq_priority;
  integer fails = 0, check_count = 0, dma_cnt = 0, i, n, cyc;
  // each row: address beside its reset value
  reg [39:0] rows [0:16] = '{40'h00_0000_0000, 40'h04_0000_0000, 40'h08_0000_0000, 40'h0C_0000_0000,
    40'h10_0000_0000, 40'h14_0000_0000, 40'h18_0000_0000, 40'h1C_0000_0000, 40'h20_0000_FFFF,
    40'h24_0000_FFFF, 40'h28_0000_FFFF, 40'h2C_0000_FFFF, 40'h30_0000_0000, 40'h34_0000_0000,
    40'h38_0000_0000, 40'h40_0000_0000, 40'hFC_0000_0000};
  assign hready = hreadyout;
  ctp_top u_ctp_top (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout,
    .hresp, .hrdata, .external_count_pin, .gate_pin, .cpu_idle, .irq, .irq_priority, .dma_request);
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  always @(posedge hclk) if (dma_request === 1'b1) dma_cnt <= dma_cnt + 1;
  task wrap_up;
    begin
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
    end
  endtask
  task check(input [31:0] got, input [31:0] exp, input [8*16-1:0] what);
    begin
      check_count = check_count + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("[FAIL] %0t %0s got %h expected %h", $time, what, got, exp);
      end
    end
  endtask
  task wait_cond(input integer lim, input bit for_irq);
    begin
      cyc = 0;
      do begin
        @(posedge hclk);
        cyc = cyc + 1;
      end while ((for_irq ? irq : hreadyout) !== 1'b1 && cyc < lim);
      if ((for_irq ? irq : hreadyout) !== 1'b1) begin
        fails = fails + 1;
        $display("[FAIL] %0t wait ran out", $time);
        wrap_up;
      end
    end
  endtask
  // caller sits just after a rising edge
  task bus(input bit wr, input [7:0] a, input [31:0] d);
    begin
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'b10;
      hwrite <= wr;
      wait_cond(100, 1'b0);
      htrans <= 2'b00;
      hwdata <= d;
      wait_cond(100, 1'b0);
      rd = hrdata;
    end
  endtask
  // count pin edges, slow enough for the two-stage synchroniser
  task pulses(input integer k);
    repeat (k) begin
      external_count_pin[2] <= 1'b1;
      repeat (4) @(posedge hclk);
      external_count_pin[2] <= 1'b0;
      repeat (4) @(posedge hclk);
    end
  endtask
  initial begin
    {hsel, hwrite, haddr, htrans, hwdata, cpu_idle, external_count_pin, gate_pin} = '0;
    hsize = 3'h2;
    hresetn = 1'b0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (i = 0; i < 17; i = i + 1) begin
      bus(1'b0, rows[i][39:32], 32'h0);
      check(rd, rows[i][31:0], "reset value");
    end
    // single low timer a, prescale 1:8, period 4
    bus(1'b1, `CTP_OFF_IRQ_PRIO, 32'h0000_0035);
    bus(1'b1, `CTP_OFF_PER_LO_A, 32'h0000_0004);
    bus(1'b1, `CTP_OFF_IRQ_MASK, 32'h0000_0001);
    n = dma_cnt;
    bus(1'b1, `CTP_OFF_CTRL_LO_A, 32'h0000_8010);
    wait_cond(200, 1'b1);
    check(32'(cyc > 30 && cyc < 50), 32'h1, "prescaled");
    check(32'(irq_priority), 32'h5, "priority a lo");
    bus(1'b1, `CTP_OFF_CTRL_LO_A, 32'h0);
    check(32'(dma_cnt > n), 32'h1, "dma pair a");
    bus(1'b0, `CTP_OFF_IRQ_STAT, 32'h0);
    check(rd, 32'h1, "status single");
    bus(1'b0, `CTP_OFF_IRQ_STAT, 32'h0);
    check(rd, 32'h0, "read clears");
    check(32'(irq), 32'h0, "irq dropped");
    // joined pair a; high control settings must be ignored
    bus(1'b1, `CTP_OFF_PER_HI_A, 32'h0000_0001);
    bus(1'b1, `CTP_OFF_PER_LO_A, 32'h0000_0003);
    bus(1'b1, `CTP_OFF_IRQ_MASK, 32'h0000_0003);
    bus(1'b1, `CTP_OFF_CTRL_HI_A, 32'h0000_8032);
    bus(1'b1, `CTP_OFF_CTRL_LO_A, 32'h0000_8008);
    repeat (20) @(posedge hclk);
    bus(1'b0, `CTP_OFF_CNT_HI_A, 32'h0);
    check(rd, 32'h0, "joined high");
    bus(1'b0, `CTP_OFF_CNT_LO_A, 32'h0);
    check(32'(rd > 32'h10 && rd < 32'h30), 32'h1, "joined low");
    wait_cond(70000, 1'b1);
    check(32'(cyc > 65500), 32'h1, "joined period");
    check(32'(irq_priority), 32'h6, "priority hi");
    bus(1'b1, `CTP_OFF_CTRL_LO_A, 32'h0);
    bus(1'b1, `CTP_OFF_CTRL_HI_A, 32'h0);
    bus(1'b0, `CTP_OFF_IRQ_STAT, 32'h0);
    check(rd, 32'h2, "joined status");
    // synchronous counter on low timer b, period 5
    bus(1'b1, `CTP_OFF_PER_LO_B, 32'h0000_0005);
    bus(1'b1, `CTP_OFF_IRQ_MASK, 32'h0000_0004);
    bus(1'b0, `CTP_OFF_IRQ_STAT, 32'h0);
    n = dma_cnt;
    bus(1'b1, `CTP_OFF_CTRL_LO_B, 32'h0000_8002);
    pulses(3);
    bus(1'b0, `CTP_OFF_CNT_LO_B, 32'h0);
    check(rd, 32'h3, "pin count");
    pulses(3);
    bus(1'b0, `CTP_OFF_CNT_LO_B, 32'h0);
    check(rd, 32'h0, "pin wrap");
    check(32'(irq), 32'h1, "irq b");
    bus(1'b0, `CTP_OFF_IRQ_STAT, 32'h0);
    check(rd, 32'h4, "status b");
    check(dma_cnt, n, "no dma pair b");
    // joined pair b in gated timer mode: counts while the gate is high, flags at its fall
    bus(1'b1, `CTP_OFF_IRQ_MASK, 32'h0000_0008);
    bus(1'b1, `CTP_OFF_CTRL_LO_B, 32'h0000_8048);
    gate_pin[2] <= 1'b1;
    repeat (10) @(posedge hclk);
    gate_pin[2] <= 1'b0;
    repeat (4) @(posedge hclk);
    bus(1'b0, `CTP_OFF_CNT_LO_B, 32'h0);
    check(rd, 32'hA, "gated count");
    bus(1'b0, `CTP_OFF_CNT_HI_B, 32'h0);
    check(rd, 32'h0, "gated high");
    check(32'(irq), 32'h1, "gate end irq");
    // reset in mid-run, with an interrupt pending
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    check(32'(irq), 32'h0, "irq in reset");
    hresetn <= 1'b1;
    @(posedge hclk);
    bus(1'b0, `CTP_OFF_CTRL_LO_B, 32'h0);
    check(rd, 32'h0, "ctrl after reset");
    bus(1'b0, `CTP_OFF_PER_LO_B, 32'h0);
    check(rd, 32'hFFFF, "period after rst");
    bus(1'b0, `CTP_OFF_IRQ_STAT, 32'h0);
    check(rd, 32'h0, "stat after reset");
    wrap_up;
  end
endmodule
